// file: logic/pic_params.svh
// constants of the phy interrupt control and counter block
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// register indices, byte address is four times the index
`define PIC_IDX_GEN_STATUS   8'h10
`define PIC_IDX_INT_CTRL     8'h11
`define PIC_IDX_INT_STAT     8'h12
`define PIC_IDX_FC_CNT       8'h14
`define PIC_IDX_RXERR_CNT    8'h15

// interrupt control fields
`define PIC_CTL_W            3
`define PIC_CTL_TEST_INTERRUPT_FORCE_BIT     2
`define PIC_CTL_EVENT_INTERRUPT_ENABLE_BIT    1
`define PIC_CTL_OE_BIT       0
`define PIC_CTL_RST          3'h0

// interrupt status and enable fields
`define PIC_EVT_N            7
`define PIC_STAT_LSB         8
`define PIC_EN_LSB           0
`define PIC_EVT_RST          7'h00

// event positions inside the event vector
`define PIC_EV_ED            6
`define PIC_EV_LINK          5
`define PIC_EV_SPEED         4
`define PIC_EV_DUPLEX        3
`define PIC_EV_ANEG          2
`define PIC_EV_FC_HALF       1
`define PIC_EV_RX_HALF       0

// general status pending bit
`define PIC_GEN_IRQ_BIT      7

// counters
`define PIC_CNT_W            8
`define PIC_CNT_RST          8'h00

`endif

// file: logic/pic_pkg.sv
// types of the phy interrupt control and counter block
package pic_pkg;

`include "pic_params.svh"

    typedef struct packed {
        logic [`PIC_CTL_W-1:0] ctl;
        logic [`PIC_EVT_N-1:0] status;
        logic [`PIC_EVT_N-1:0] en;
        logic [`PIC_EVT_N-1:0] snap;
        logic                  rx_counted;
        logic                  pending;
        logic [31:0]           prdata;
        logic                  pslverr;
    } pic_top_s;

    typedef struct packed {
        logic out;
        logic oe;
        logic pd;
    } pic_pin_s;

endpackage

// file: logic/pic_sat_counter.sv
// saturating clear-on-read event counter with half-range pulse
`timescale 1ns/100ps
module pic_sat_counter #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         inc,
    input  wire logic         cap,
    input  wire logic         clr,
    output      logic [W-1:0] count,
    output      logic         half_evt
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] snap;
        logic         half;
    } pic_cnt_s;

    pic_cnt_s s_q;
    pic_cnt_s s_d;
    logic [W-1:0] base;

    if (W < 2) begin : g_chk
        $error("counter width must be at least 2");
    end

    always_comb begin
        s_d  = s_q;
        base = s_q.cnt;
        if (cap) begin
            s_d.snap = s_q.cnt;
        end
        if (clr) begin
            base = W'(s_q.cnt - s_q.snap);
        end
        if (inc && base != {W{1'b1}}) begin
            s_d.cnt = W'(base + 1'b1);
        end else begin
            s_d.cnt = base;
        end
        s_d.half = ~s_q.cnt[W-1] & s_d.cnt[W-1];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count    = s_q.cnt;
    assign half_evt = s_q.half;
endmodule

// file: logic/pic_irq_pin.sv
// shared power-down input or interrupt output pin
`timescale 1ns/100ps
module pic_irq_pin #(
    parameter bit IRQ_ACTIVE_LOW = 1'b1,
    parameter bit PD_ACTIVE_LOW  = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic out_en,
    input  wire logic irq_req,
    input  wire logic pin_in,
    output      logic pin_out,
    output      logic pin_oe,
    output      logic powerdown_req
);
    pic_pkg::pic_pin_s s_q;
    pic_pkg::pic_pin_s s_d;

    always_comb begin
        s_d     = s_q;
        s_d.oe  = out_en;
        s_d.out = irq_req ^ IRQ_ACTIVE_LOW;
        s_d.pd  = out_en ? 1'b0 : (pin_in ^ PD_ACTIVE_LOW);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.oe  <= 1'b0;
            s_q.out <= IRQ_ACTIVE_LOW;
            s_q.pd  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_out       = s_q.out;
    assign pin_oe        = s_q.oe;
    assign powerdown_req = s_q.pd;
endmodule

// file: logic/pic_irq_ctrl.sv
// phy interrupt control, event status and error counters behind apb
`timescale 1ns/100ps
`include "pic_params.svh"

module pic_irq_ctrl #(
    parameter int AW             = 8,
    parameter int CW             = `PIC_CNT_W,
    parameter bit IRQ_ACTIVE_LOW = 1'b1,
    parameter bit PD_ACTIVE_LOW  = 1'b1
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output      logic [31:0]   prdata,
    output      logic          pready,
    output      logic          pslverr,
    input  wire logic          energy_detect_change,
    input  wire logic          link_change,
    input  wire logic          speed_change,
    input  wire logic          duplex_change,
    input  wire logic          autoneg_done,
    input  wire logic          false_carrier,
    input  wire logic          carrier_valid,
    input  wire logic          symbol_error,
    input  wire logic          collision,
    input  wire logic          pin_in,
    output      logic          pin_out,
    output      logic          pin_oe,
    output      logic          powerdown_req,
    output      logic          irq_pending,
    output      logic [CW-1:0] false_carrier_count,
    output      logic [CW-1:0] rx_error_count
);
    pic_pkg::pic_top_s s_q;
    pic_pkg::pic_top_s s_d;

    logic                  setup_ph;
    logic                  setup_rd;
    logic                  acc_ph;
    logic                  wr_done;
    logic                  rd_done;
    logic                  hit_gen;
    logic                  hit_ctl;
    logic                  hit_stat;
    logic                  hit_fc;
    logic                  hit_rx;
    logic                  mapped;
    logic                  rx_inc;
    logic                  fc_half;
    logic                  rx_half;
    logic                  ev_irq;
    logic [`PIC_EVT_N-1:0] evt;
    logic [CW-1:0]         fc_cnt;
    logic [CW-1:0]         rx_cnt;
    logic [31:0]           rd_val;
    logic [`PIC_EVT_N-1:0] ev_hit;
    logic [`PIC_EVT_N-1:0] clr_mask;
    logic [`PIC_EVT_N-1:0] en_wr;
    logic                  ctl_wr;
    logic                  stat_wr;
    logic                  stat_rd;

    if (AW < 7 || AW > 32) begin : g_aw_chk
        $error("address width must lie between 7 and 32");
    end
    if (CW != `PIC_CNT_W) begin : g_cw_chk
        $error("counter width must be eight");
    end
    if (`PIC_CTL_W > 8) begin : g_ctl_chk
        $error("control field must fit in byte lane zero");
    end
    if (`PIC_EN_LSB + `PIC_EVT_N > 8) begin : g_en_chk
        $error("event enables must fit in byte lane zero");
    end
    if (`PIC_STAT_LSB + `PIC_EVT_N > 16) begin : g_stat_chk
        $error("event status must fit in the low half word");
    end
    if (`PIC_EN_LSB + `PIC_EVT_N > `PIC_STAT_LSB) begin : g_ovl_chk
        $error("event status and enable fields overlap");
    end
    if (`PIC_GEN_IRQ_BIT > 15) begin : g_gen_chk
        $error("pending mirror must lie in the low half word");
    end

    function automatic logic reg_hit(input logic [AW-1:0] a, input logic [7:0] idx);
        reg_hit = (a == AW'({idx, 2'b00}));
    endfunction

    function automatic logic [31:0] cnt_word(input logic [CW-1:0] c);
        cnt_word = {{(32-CW){1'b0}}, c};
    endfunction

    function automatic logic latch_bit(input logic old, input logic clr, input logic set);
        latch_bit = (old & ~clr) | set;
    endfunction

    // apb phase decode, zero wait states
    always_comb begin
        setup_ph = psel & ~penable;
        setup_rd = setup_ph & ~pwrite;
        acc_ph   = psel & penable;
        wr_done  = acc_ph & pwrite;
        rd_done  = acc_ph & ~pwrite;
        hit_gen  = reg_hit(paddr, `PIC_IDX_GEN_STATUS);
        hit_ctl  = reg_hit(paddr, `PIC_IDX_INT_CTRL);
        hit_stat = reg_hit(paddr, `PIC_IDX_INT_STAT);
        hit_fc   = reg_hit(paddr, `PIC_IDX_FC_CNT);
        hit_rx   = reg_hit(paddr, `PIC_IDX_RXERR_CNT);
        mapped   = hit_gen | hit_ctl | hit_stat | hit_fc | hit_rx;
    end

    // write strobes and read-clear mask
    always_comb begin
        ctl_wr   = wr_done & hit_ctl & pstrb[0];
        stat_wr  = wr_done & hit_stat & pstrb[0];
        stat_rd  = rd_done & hit_stat;
        clr_mask = stat_rd ? s_q.snap : '0;
        en_wr    = pwdata[`PIC_EN_LSB +: `PIC_EVT_N];
    end

    // once per carrier, none in collision
    always_comb begin
        rx_inc = carrier_valid & symbol_error & ~collision & ~s_q.rx_counted;
    end

    pic_sat_counter #(
        .W        (CW)
    ) u_fc_cnt (
        .clk      (clk),
        .rst      (rst),
        .inc      (false_carrier),
        .cap      (setup_rd & hit_fc),
        .clr      (rd_done & hit_fc),
        .count    (fc_cnt),
        .half_evt (fc_half)
    );

    pic_sat_counter #(
        .W        (CW)
    ) u_rx_cnt (
        .clk      (clk),
        .rst      (rst),
        .inc      (rx_inc),
        .cap      (setup_rd & hit_rx),
        .clr      (rd_done & hit_rx),
        .count    (rx_cnt),
        .half_evt (rx_half)
    );

    always_comb begin
        evt                  = '0;
        evt[`PIC_EV_ED]      = energy_detect_change;
        evt[`PIC_EV_LINK]    = link_change;
        evt[`PIC_EV_SPEED]   = speed_change;
        evt[`PIC_EV_DUPLEX]  = duplex_change;
        evt[`PIC_EV_ANEG]    = autoneg_done;
        evt[`PIC_EV_FC_HALF] = fc_half;
        evt[`PIC_EV_RX_HALF] = rx_half;
    end

    // read value selection
    always_comb begin
        rd_val = '0;
        if (hit_gen) begin
            rd_val[`PIC_GEN_IRQ_BIT] = s_q.pending;
        end
        if (hit_ctl) begin
            rd_val[`PIC_CTL_W-1:0] = s_q.ctl;
        end
        if (hit_stat) begin
            rd_val[`PIC_STAT_LSB + `PIC_EV_ED]      = s_q.status[`PIC_EV_ED];
            rd_val[`PIC_EN_LSB + `PIC_EV_ED]        = s_q.en[`PIC_EV_ED];
            rd_val[`PIC_STAT_LSB + `PIC_EV_LINK]    = s_q.status[`PIC_EV_LINK];
            rd_val[`PIC_EN_LSB + `PIC_EV_LINK]      = s_q.en[`PIC_EV_LINK];
            rd_val[`PIC_STAT_LSB + `PIC_EV_SPEED]   = s_q.status[`PIC_EV_SPEED];
            rd_val[`PIC_EN_LSB + `PIC_EV_SPEED]     = s_q.en[`PIC_EV_SPEED];
            rd_val[`PIC_STAT_LSB + `PIC_EV_DUPLEX]  = s_q.status[`PIC_EV_DUPLEX];
            rd_val[`PIC_EN_LSB + `PIC_EV_DUPLEX]    = s_q.en[`PIC_EV_DUPLEX];
            rd_val[`PIC_STAT_LSB + `PIC_EV_ANEG]    = s_q.status[`PIC_EV_ANEG];
            rd_val[`PIC_EN_LSB + `PIC_EV_ANEG]      = s_q.en[`PIC_EV_ANEG];
            rd_val[`PIC_STAT_LSB + `PIC_EV_FC_HALF] = s_q.status[`PIC_EV_FC_HALF];
            rd_val[`PIC_EN_LSB + `PIC_EV_FC_HALF]   = s_q.en[`PIC_EV_FC_HALF];
            rd_val[`PIC_STAT_LSB + `PIC_EV_RX_HALF] = s_q.status[`PIC_EV_RX_HALF];
            rd_val[`PIC_EN_LSB + `PIC_EV_RX_HALF]   = s_q.en[`PIC_EV_RX_HALF];
        end
        if (hit_fc) begin
            rd_val = cnt_word(fc_cnt);
        end
        if (hit_rx) begin
            rd_val = cnt_word(rx_cnt);
        end
    end

    always_comb begin
        s_d = s_q;

        s_d.rx_counted = carrier_valid & (s_q.rx_counted | rx_inc);

        // capture read data and error in the setup cycle
        if (setup_ph) begin
            s_d.pslverr = ~mapped;
            s_d.prdata  = pwrite ? 32'h0000_0000 : rd_val;
            if (~pwrite && hit_stat) begin
                s_d.snap = s_q.status;
            end
        end

        // clear on read drops only bits returned
        if (stat_rd) begin
            s_d.snap = '0;
        end

        // latch events, set wins over clear
        s_d.status[`PIC_EV_ED] = latch_bit(s_q.status[`PIC_EV_ED],
            clr_mask[`PIC_EV_ED], evt[`PIC_EV_ED]);
        s_d.status[`PIC_EV_LINK] = latch_bit(s_q.status[`PIC_EV_LINK],
            clr_mask[`PIC_EV_LINK], evt[`PIC_EV_LINK]);
        s_d.status[`PIC_EV_SPEED] = latch_bit(s_q.status[`PIC_EV_SPEED],
            clr_mask[`PIC_EV_SPEED], evt[`PIC_EV_SPEED]);
        s_d.status[`PIC_EV_DUPLEX] = latch_bit(s_q.status[`PIC_EV_DUPLEX],
            clr_mask[`PIC_EV_DUPLEX], evt[`PIC_EV_DUPLEX]);
        s_d.status[`PIC_EV_ANEG] = latch_bit(s_q.status[`PIC_EV_ANEG],
            clr_mask[`PIC_EV_ANEG], evt[`PIC_EV_ANEG]);
        // false carrier half clear on read
        s_d.status[`PIC_EV_FC_HALF] = latch_bit(s_q.status[`PIC_EV_FC_HALF],
            clr_mask[`PIC_EV_FC_HALF], evt[`PIC_EV_FC_HALF]);
        // rx error half clear on read
        s_d.status[`PIC_EV_RX_HALF] = latch_bit(s_q.status[`PIC_EV_RX_HALF],
            clr_mask[`PIC_EV_RX_HALF], evt[`PIC_EV_RX_HALF]);

        // writes to upper control bits ignored
        if (ctl_wr) begin
            s_d.ctl = pwdata[`PIC_CTL_W-1:0];
        end
        if (stat_wr) begin
            s_d.en[`PIC_EV_ED]      = en_wr[`PIC_EV_ED];
            s_d.en[`PIC_EV_LINK]    = en_wr[`PIC_EV_LINK];
            s_d.en[`PIC_EV_SPEED]   = en_wr[`PIC_EV_SPEED];
            s_d.en[`PIC_EV_DUPLEX]  = en_wr[`PIC_EV_DUPLEX];
            s_d.en[`PIC_EV_ANEG]    = en_wr[`PIC_EV_ANEG];
            s_d.en[`PIC_EV_FC_HALF] = en_wr[`PIC_EV_FC_HALF];
            s_d.en[`PIC_EV_RX_HALF] = en_wr[`PIC_EV_RX_HALF];
        end

        ev_hit = s_d.status & s_d.en;
        ev_irq = s_d.ctl[`PIC_CTL_EVENT_INTERRUPT_ENABLE_BIT] & (|ev_hit);
        s_d.pending = s_d.ctl[`PIC_CTL_TEST_INTERRUPT_FORCE_BIT] | ev_irq;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.ctl        <= `PIC_CTL_RST;
            s_q.status     <= `PIC_EVT_RST;
            s_q.en         <= `PIC_EVT_RST;
            s_q.snap       <= `PIC_EVT_RST;
            s_q.rx_counted <= 1'b0;
            s_q.pending    <= 1'b0;
            s_q.prdata     <= 32'h0000_0000;
            s_q.pslverr    <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // pin turned to output by enable
    pic_irq_pin #(
        .IRQ_ACTIVE_LOW (IRQ_ACTIVE_LOW),
        .PD_ACTIVE_LOW  (PD_ACTIVE_LOW)
    ) u_pin (
        .clk            (clk),
        .rst            (rst),
        .out_en         (s_q.ctl[`PIC_CTL_OE_BIT]),
        .irq_req        (s_q.pending),
        .pin_in         (pin_in),
        .pin_out        (pin_out),
        .pin_oe         (pin_oe),
        .powerdown_req  (powerdown_req)
    );

    assign prdata              = s_q.prdata;
    assign pready              = acc_ph;
    assign pslverr             = acc_ph & s_q.pslverr;
    assign irq_pending         = s_q.pending;
    assign false_carrier_count = fc_cnt;
    assign rx_error_count      = rx_cnt;
endmodule

// file: tb/pic_irq_ctrl_checker.sv
// port assertions of the interrupt control block
`timescale 1ns/100ps
module pic_irq_ctrl_checker #(
    parameter int AW = 8,
    parameter int CW = 8
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [3:0]    pstrb,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          false_carrier,
    input wire logic          pin_out,
    input wire logic          pin_oe,
    input wire logic          powerdown_req,
    input wire logic          irq_pending,
    input wire logic [CW-1:0] false_carrier_count
);
    logic acc;
    logic rdc;
    logic wrc;
    assign acc = psel && penable;
    assign rdc = acc && !pwrite;
    assign wrc = acc && pwrite && pstrb[0] && paddr == 8'h44;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ready; pready == acc; endproperty
    a_ready: assert property (p_ready) else $error("pready not zero wait");
    property p_map; acc |-> pslverr == !(paddr inside {8'h40, 8'h44, 8'h48, 8'h50, 8'h54}); endproperty
    a_map: assert property (p_map) else $error("pslverr wrong");
    property p_ctl_rsv; rdc && paddr == 8'h44 |-> prdata[31:3] == 0; endproperty
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("control upper bits set");
    property p_stat_rsv; rdc && paddr == 8'h48 |-> !prdata[15] && !prdata[7]; endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved set");
    property p_fc_rsv; rdc && paddr == 8'h50 |-> prdata[31:8] == 0; endproperty
    a_fc_rsv: assert property (p_fc_rsv) else $error("counter upper bits set");
    property p_test_interrupt_force; wrc && pwdata[2] |=> irq_pending [*2]; endproperty
    a_test_interrupt_force: assert property (p_test_interrupt_force) else $error("forced interrupt missing");
    property p_oe; wrc |-> ##2 pin_oe == $past(pwdata[0], 2); endproperty
    a_oe: assert property (p_oe) else $error("pin drive not per enable");
    property p_pd; pin_oe |-> !powerdown_req; endproperty
    a_pd: assert property (p_pd) else $error("powerdown while driving");
    property p_pin; pin_oe && $past(pin_oe) |-> pin_out == !$past(irq_pending); endproperty
    a_pin: assert property (p_pin) else $error("pin level wrong");
    property p_sat; false_carrier_count == '1 && !psel |=> false_carrier_count == '1; endproperty
    a_sat: assert property (p_sat) else $error("counter left max");
    property p_inc;
        false_carrier && false_carrier_count != '1 && !psel
        |=> false_carrier_count == $past(false_carrier_count) + 1'b1;
    endproperty
    a_inc: assert property (p_inc) else $error("counter did not step");
    c_test_interrupt_force: cover property (wrc && pwdata[2]);
    c_sat: cover property (false_carrier && false_carrier_count == '1);
    c_err: cover property (acc && pslverr);
endmodule
bind pic_irq_ctrl pic_irq_ctrl_checker #(.AW(AW), .CW(CW)) chk_i (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .false_carrier(false_carrier), .pin_out(pin_out), .pin_oe(pin_oe),
    .powerdown_req(powerdown_req), .irq_pending(irq_pending),
    .false_carrier_count(false_carrier_count));

// file: tb/pic_host_model.sv
// host side of the shared pin: pull-up, power-down drive, irq sense
`timescale 1ns/100ps
module pic_host_model (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic pd_drive,
    output      logic pin_in,
    output      logic irq_seen
);
    assign pin_in = pin_oe ? pin_out : !pd_drive;
    assign irq_seen = pin_oe && !pin_out;
endmodule

// file: tb/pic_irq_ctrl_tb_top.sv
// self-checking bench of the interrupt control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pic_irq_ctrl_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [3:0]  strb = 4'hF;
    logic [4:0]  ev = 5'h00;
    logic        fc = 1'b0;
    logic        cv = 1'b0;
    logic        se = 1'b0;
    logic        col = 1'b0;
    logic        pd = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [7:0]  fcc;
    logic [7:0]  rxc;
    logic        pready, pslverr, pin_in, pin_out, pin_oe, pdr, irq_pending, irq_seen, er;
    int          err_total = 0;
    int          check_count = 0;
    always #2.5 clk = ~clk;
    pic_irq_ctrl pic_irq_ctrl_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .energy_detect_change(ev[4]),
        .link_change(ev[3]), .speed_change(ev[2]), .duplex_change(ev[1]),
        .autoneg_done(ev[0]), .false_carrier(fc), .carrier_valid(cv), .symbol_error(se),
        .collision(col), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .powerdown_req(pdr), .irq_pending(irq_pending), .false_carrier_count(fcc),
        .rx_error_count(rxc));
    pic_host_model pic_host_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .pd_drive(pd),
        .pin_in(pin_in), .irq_seen(irq_seen));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic fcp(input int n);
        repeat (n) begin
            @(posedge clk);
            fc <= 1'b1;
        end
        @(posedge clk);
        fc <= 1'b0;
    endtask
    task automatic carrier(input logic c);
        @(posedge clk);
        cv <= 1'b1;
        se <= 1'b1;
        col <= c;
        repeat (3) @(posedge clk);
        cv <= 1'b0;
        se <= 1'b0;
        col <= 1'b0;
    endtask
    task automatic t_reset;
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, 8'h40 + 8'(k < 3 ? 4 * k : 4 * k + 4), 32'h0);
            `CHK("reset value", 32'h0, rd)
        end
        apb(1'b0, 8'h60, 32'h0);
        `CHK("unmapped", 1'b1, er)
        $display("t_reset done");
    endtask
    task automatic t_ctl;
        apb(1'b1, 8'h44, 32'hFFFFFFFF);
        strb = 4'hE;
        apb(1'b1, 8'h44, 32'h0);
        strb = 4'hF;
        apb(1'b0, 8'h44, 32'h0);
        `CHK("ctl read", 32'h7, rd)
        `CHK("test_interrupt_force pending", 1'b1, irq_pending)
        `CHK("test_interrupt_force pin", 1'b1, irq_seen)
        apb(1'b1, 8'h44, 32'h0);
        @(posedge clk);
        pd <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK("test_interrupt_force off", 1'b0, irq_pending)
        `CHK("pin input", 1'b1, pdr)
        @(posedge clk);
        pd <= 1'b0;
        $display("t_ctl done");
    endtask
    task automatic t_events;
        apb(1'b1, 8'h44, 32'h1);
        apb(1'b1, 8'h48, 32'hFFFF);
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            `CHK("no global", 1'b0, irq_pending)
            apb(1'b0, 8'h48, 32'h0);
            `CHK("status set", 32'h7F | (32'h1 << (10 + i)), rd)
            apb(1'b0, 8'h48, 32'h0);
            `CHK("status clr", 32'h7F, rd)
        end
        apb(1'b1, 8'h44, 32'h2);
        apb(1'b1, 8'h48, 32'h40);
        pulse(4);
        `CHK("no oe pin", 1'b0, irq_seen)
        `CHK("no oe drive", 1'b0, pin_oe)
        apb(1'b0, 8'h48, 32'h0);
        `CHK("ed status", 32'h4040, rd)
        apb(1'b1, 8'h44, 32'h3);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'h48, 32'h1 << (2 + i));
            pulse(i);
            `CHK("irq pin", 1'b1, irq_seen)
            apb(1'b0, 8'h40, 32'h0);
            `CHK("gen pending", 32'h80, rd)
            apb(1'b0, 8'h48, 32'h0);
            `CHK("status", (32'h1 << (10 + i)) | (32'h1 << (2 + i)), rd)
            `CHK("cleared", 1'b0, irq_pending)
            pulse((i + 1) % 5);
            `CHK("other off", 1'b0, irq_pending)
            apb(1'b0, 8'h48, 32'h0);
        end
        $display("t_events done");
    endtask
    task automatic t_count;
        apb(1'b1, 8'h48, 32'h3);
        fcp(128);
        repeat (3) @(posedge clk);
        #1;
        `CHK("fc half irq", 1'b1, irq_pending)
        apb(1'b0, 8'h50, 32'h0);
        `CHK("fc count", 32'h80, rd)
        apb(1'b0, 8'h50, 32'h0);
        `CHK("fc clear", 32'h0, rd)
        apb(1'b0, 8'h48, 32'h0);
        `CHK("fc half", 32'h203, rd)
        fcp(300);
        `CHK("fc port", 8'hFF, fcc)
        apb(1'b0, 8'h50, 32'h0);
        `CHK("fc sat", 32'hFF, rd)
        apb(1'b0, 8'h48, 32'h0);
        `CHK("fc recross", 32'h203, rd)
        carrier(1'b1);
        carrier(1'b0);
        apb(1'b0, 8'h54, 32'h0);
        `CHK("rx once", 32'h1, rd)
        repeat (128) carrier(1'b0);
        apb(1'b0, 8'h48, 32'h0);
        `CHK("rx half", 32'h103, rd)
        `CHK("rx count", 8'h80, rxc)
        $display("t_count done");
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ctl();
        t_events();
        t_count();
        final_report();
    end
endmodule
